// File: core/csp_clock_control.sv
// Clock source selection, start-up gating, trim register and prescale register over APB.
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "csp_defs.svh"

// What this block does
// - Code 0110 selects low-frequency crystal source
// - Crystal start-up: 1K/4ms, 1K/64ms, 32K/64ms
// - Code 0010 selects internal 8 MHz RC
// - Reset loads factory calibration into trim
// - RC: wake 6 cycles, reset 14 plus delay
// - Watchdog oscillator times watchdog and reset delay
// - Code 0000 selects external clock input
// - External: wake 6 cycles, reset 14 plus delay
// - Code 0100 selects 128 kHz oscillator, same delays
// - Prescaler divides every source for all domains
// - Division change produces no glitch or short period
// - New rate active within two divided edges
// - Divider counts undivided source, state hidden
// - Unlock write then select write within four
// - Select codes 0 to 8 divide 1 to 256
// - Select resets to 0 or 3 per fuse
module csp_clock_control
	import csp_pkg::*;
#(
	parameter int LF_LONG_CYCLES  = `CSP_LF_LONG_CYCLES,
	parameter int WDT_LONG_CYCLES = `CSP_WDT_64MS_CYCLES
) (
	// Clock and reset.
	input  wire logic                   core_clk,
	input  wire logic                   sys_rst,
	// APB slave.
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [`CSP_ADDR_W-1:0] paddr,
	input  wire logic [31:0]            pwdata,
	output logic [31:0]                 prdata,
	output logic                        pready,
	output logic                        pslverr,
	// Fuses and factory calibration.
	input  wire logic [3:0]             clockSourceSelectFuses,
	input  wire logic [1:0]             startupTimeFuses,
	input  wire logic                   divideByEightFuse,
	input  wire logic [7:0]             factoryTrim,
	// Oscillator outputs, asynchronous to core_clk.
	input  wire logic                   externalClockInput,
	input  wire logic                   rcOscillator,
	input  wire logic                   lowPowerOscillator,
	input  wire logic                   lowFreqCrystal,
	// Power-down request from the core.
	input  wire logic                   sleepReq,
	// Outputs.
	output logic [7:0]                  rcTrimValue,
	output logic                        watchdogTick,
	output logic                        coreDomainClockEn,
	output logic                        peripheralDomainClockEn,
	output logic                        converterDomainClockEn,
	output logic                        programMemoryDomainClockEn,
	output logic                        clocksRunning
);
	localparam int NOSC  = 4;
	localparam int NFUSE = 15;

	logic [NOSC-1:0]  oscMeta;
	logic [NOSC-1:0]  oscSync;
	logic [NOSC-1:0]  oscLast;
	logic [NOSC-1:0]  oscTick;
	logic [NFUSE-1:0] fuseMeta;
	logic [NFUSE-1:0] fuseSync;
	logic [3:0]       srcCode;
	logic [1:0]       sutCode;
	logic             div8Programmed;
	logic [7:0]       trimFactory;
	csp_source_t      srcKind;
	logic             srcTick;
	logic             divTick;
	logic [3:0]       activeSel;
	logic             startDone;
	logic             startPulse;
	logic [15:0]      srcCount;
	logic [13:0]      wdtCount;
	logic [15:0]      lfSrcCount;
	logic             badSrc;
	logic             badSut;
	logic             rstDlyReg;
	logic             sleepLastReg;
	logic [3:0]       selReg;
	logic [3:0]       selNext;
	logic [2:0]       unlockReg;
	logic [2:0]       unlockNext;
	logic [7:0]       trimReg;
	logic [7:0]       trimNext;
	logic [31:0]      rdataNext;
	logic [31:0]      prdataReg;
	logic             domainEnReg;
	logic             domainEnNext;
	logic             wdtTickReg;
	logic             setup;
	logic             access;
	logic             mapped;
	logic             rstDlyNext;
	logic             sleepLastNext;
	logic             wdtTickNext;
	logic [31:0]      prdataNext;

	// Word match used by the map check and by each write decode.
	function automatic logic hits(input logic [`CSP_ADDR_W-1:0] addr,
		input logic [`CSP_ADDR_W-1:0] offset);
		hits = (addr == offset);
	endfunction : hits

	// Oscillator pins: two flops, then a third for the rising-edge tick.
	genvar gi;
	generate
		for (gi = 0; gi < NOSC; gi++) begin : g_osc
			always_ff @(posedge core_clk) begin
				oscMeta[gi] <= (gi == 0) ? externalClockInput :
					(gi == 1) ? rcOscillator :
					(gi == 2) ? lowPowerOscillator : lowFreqCrystal;
				oscSync[gi] <= oscMeta[gi];
				oscLast[gi] <= oscSync[gi];
			end
			assign oscTick[gi] = oscSync[gi] & ~oscLast[gi];
		end
	endgenerate

	// Fuses are static, so a plain two-flop bus synchroniser is enough.
	always_ff @(posedge core_clk) begin
		fuseMeta <= {factoryTrim, divideByEightFuse, startupTimeFuses, clockSourceSelectFuses};
		fuseSync <= fuseMeta;
	end

	assign srcCode        = fuseSync[3:0];
	assign sutCode        = fuseSync[5:4];
	assign div8Programmed = ~fuseSync[6];
	assign trimFactory    = fuseSync[14:7];

	assign srcKind = csp_decode_source(srcCode);
	assign badSrc  = (srcCode != `CSP_SRC_EXTERNAL) && (srcCode != `CSP_SRC_RC8M) &&
		(srcCode != `CSP_SRC_LOWPOWER) && (srcCode != `CSP_SRC_LFXTAL);
	assign badSut  = (sutCode == `CSP_SUT_RESERVED);

	always_comb begin
		case (srcKind)
			SRC_EXTERNAL: srcTick = oscTick[0];
			SRC_LOWPOWER: srcTick = oscTick[2];
			SRC_LFXTAL:   srcTick = oscTick[3];
			SRC_RC8M:     srcTick = oscTick[1];
			default:      srcTick = oscTick[1];
		endcase
	end

	// A reserved start-up code takes the longest delay rather than a guess.
	assign lfSrcCount = (sutCode == `CSP_SUT_SHORT || sutCode == `CSP_SUT_MID) ?
		`CSP_LF_SHORT_CYCLES : 16'(LF_LONG_CYCLES);

	always_comb begin
		if (rstDlyReg) begin
			if (srcKind == SRC_LFXTAL) begin
				srcCount = lfSrcCount;
				wdtCount = (sutCode == `CSP_SUT_SHORT) ? `CSP_WDT_4MS_CYCLES :
					14'(WDT_LONG_CYCLES);
			end else begin
				srcCount = `CSP_RESET_CYCLES;
				case (sutCode)
					`CSP_SUT_SHORT: wdtCount = 14'h0000;
					`CSP_SUT_MID:   wdtCount = `CSP_WDT_4MS_CYCLES;
					default:        wdtCount = 14'(WDT_LONG_CYCLES);
				endcase
			end
		end else begin
			wdtCount = 14'h0000;
			srcCount = (srcKind == SRC_LFXTAL) ? lfSrcCount : `CSP_WAKE_CYCLES;
		end
	end

	// The timer restarts in the first cycle out of reset and on each wake from power-down.
	assign startPulse = (rstDlyReg & ~sys_rst) | (sleepLastReg & ~sleepReq);

	csp_startup_timer u_startup (
		.core_clk  (core_clk),
		.sys_rst   (sys_rst),
		.startPulse(startPulse),
		.abortHold (sleepReq),
		.srcCount  (srcCount),
		.wdtCount  (wdtCount),
		.srcTick   (srcTick),
		.wdtTick   (oscTick[2]),
		.startDone (startDone)
	);

	csp_prescaler u_prescaler (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.srcTick  (srcTick),
		.selIn    (selReg),
		.divTick  (divTick),
		.activeSel(activeSel)
	);

	// APB decode; every access completes in its first access cycle.
	assign setup  = psel & ~penable;
	assign access = psel & penable;
	assign mapped = hits(paddr, `CSP_OFF_PRESCALE) || hits(paddr, `CSP_OFF_TRIM) ||
		hits(paddr, `CSP_OFF_STATUS);

	always_comb begin
		selNext    = selReg;
		// The window is counted in core cycles; a late select write is dropped silently,
		// so software that cares must read the select field back.
		unlockNext = (unlockReg != 3'h0) ? unlockReg - 3'h1 : 3'h0;
		trimNext   = trimReg;
		if (access && pwrite && hits(paddr, `CSP_OFF_PRESCALE)) begin
			if (pwdata[7:0] == `CSP_UNLOCK_WORD) begin
				// Rewriting the unlock word neither extends nor ends the window.
				if (unlockReg == 3'h0) begin
					unlockNext = `CSP_UNLOCK_CYCLES;
				end
			end else if (!pwdata[`CSP_UNLOCK_BIT] && unlockReg != 3'h0) begin
				unlockNext = 3'h0;
				if (pwdata[`CSP_SEL_MSB:0] <= `CSP_SEL_MAX) begin
					selNext = pwdata[`CSP_SEL_MSB:0];
				end
			end
		end
		if (access && pwrite && hits(paddr, `CSP_OFF_TRIM)) begin
			trimNext = pwdata[7:0];
		end
	end

	always_comb begin
		rdataNext = 32'h0000_0000;
		case (paddr)
			`CSP_OFF_PRESCALE: rdataNext = {24'h00_0000, (unlockReg != 3'h0), 3'h0, selReg};
			`CSP_OFF_TRIM:     rdataNext = {24'h00_0000, trimReg};
			`CSP_OFF_STATUS: begin
				rdataNext[`CSP_STAT_RUNNING]                      = clocksRunning;
				rdataNext[`CSP_STAT_BAD_SRC]                      = badSrc;
				rdataNext[`CSP_STAT_BAD_SUT]                      = badSut;
				rdataNext[`CSP_STAT_SEL_LSB+3:`CSP_STAT_SEL_LSB] = activeSel;
				rdataNext[`CSP_STAT_SRC_LSB+3:`CSP_STAT_SRC_LSB] = srcCode;
			end
			default: rdataNext = 32'h0000_0000;
		endcase
	end

	// Every core domain sees the same divided tick, and none until start-up ends.
	assign domainEnNext = divTick & startDone & ~sleepReq;

	// Read data is taken in the setup cycle, so it stands through the whole access phase.
	always_comb begin
		rstDlyNext    = sys_rst;
		sleepLastNext = sleepReq;
		wdtTickNext   = oscTick[2];
		prdataNext    = setup ? rdataNext : prdataReg;
	end

	always_ff @(posedge core_clk) begin
		rstDlyReg <= rstDlyNext;
		if (sys_rst) begin
			sleepLastReg <= 1'b0;
			wdtTickReg   <= 1'b0;
			domainEnReg  <= 1'b0;
			prdataReg    <= 32'h0000_0000;
		end else begin
			sleepLastReg <= sleepLastNext;
			wdtTickReg   <= wdtTickNext;
			domainEnReg  <= domainEnNext;
			prdataReg    <= prdataNext;
		end
	end

	// Fuse-driven values load only while reset holds, after the fuse synchroniser settled.
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			selReg    <= div8Programmed ? `CSP_SEL_RESET_DIV8 : `CSP_SEL_RESET_PLAIN;
			unlockReg <= 3'h0;
			trimReg   <= trimFactory;
		end else begin
			selReg    <= selNext;
			unlockReg <= unlockNext;
			trimReg   <= trimNext;
		end
	end

	// Unmapped words answer with an error and read as zero; writes to them are dropped.
	assign prdata                     = prdataReg;
	assign pready                     = 1'b1;
	assign pslverr                    = access & ~mapped;
	assign rcTrimValue                = trimReg;
	assign watchdogTick               = wdtTickReg;
	assign coreDomainClockEn          = domainEnReg;
	assign peripheralDomainClockEn    = domainEnReg;
	assign converterDomainClockEn     = domainEnReg;
	assign programMemoryDomainClockEn = domainEnReg;
	assign clocksRunning              = startDone;
endmodule : csp_clock_control
`default_nettype wire

// File: core/csp_defs.svh
// Offsets, field positions, reset values and timing counts of the clock source and prescaler.
`ifndef CSP_DEFS_SVH
`define CSP_DEFS_SVH

`define CSP_ADDR_W            12
`define CSP_OFF_PRESCALE      12'h000
`define CSP_OFF_TRIM          12'h004
`define CSP_OFF_STATUS        12'h008

`define CSP_UNLOCK_BIT        7
`define CSP_UNLOCK_WORD       8'h80
`define CSP_UNLOCK_CYCLES     3'h4
`define CSP_SEL_MSB           3
`define CSP_SEL_MAX           4'h8
`define CSP_SEL_RESET_PLAIN   4'h0
`define CSP_SEL_RESET_DIV8    4'h3

`define CSP_SRC_EXTERNAL      4'h0
`define CSP_SRC_RC8M          4'h2
`define CSP_SRC_LOWPOWER      4'h4
`define CSP_SRC_LFXTAL        4'h6

`define CSP_SUT_SHORT         2'h0
`define CSP_SUT_MID           2'h1
`define CSP_SUT_LONG          2'h2
`define CSP_SUT_RESERVED      2'h3

`define CSP_WAKE_CYCLES       16'h0006
`define CSP_RESET_CYCLES      16'h000E
`define CSP_LF_SHORT_CYCLES   16'h0400
`define CSP_LF_LONG_CYCLES    32'h0000_8000
`define CSP_WDT_4MS_CYCLES    14'h0200
`define CSP_WDT_64MS_CYCLES   32'h0000_2000

`define CSP_STAT_RUNNING      0
`define CSP_STAT_BAD_SRC      1
`define CSP_STAT_BAD_SUT      2
`define CSP_STAT_SEL_LSB      4
`define CSP_STAT_SRC_LSB      8

`endif

// File: core/csp_pkg.sv
// Types and shared decoding for the clock source and prescaler.
package csp_pkg;

	typedef enum logic [1:0] {
		SRC_EXTERNAL,
		SRC_RC8M,
		SRC_LOWPOWER,
		SRC_LFXTAL
	} csp_source_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SRC_WAIT,
		ST_WDT_WAIT,
		ST_DONE
	} csp_start_state_t;

	// Reserved codes fall back to the internal RC, the shipped source; code 6 selects the crystal.
	function automatic csp_source_t csp_decode_source(input logic [3:0] code);
		case (code)
			4'h0:    csp_decode_source = SRC_EXTERNAL;
			4'h4:    csp_decode_source = SRC_LOWPOWER;
			4'h6:    csp_decode_source = SRC_LFXTAL;
			default: csp_decode_source = SRC_RC8M;
		endcase
	endfunction : csp_decode_source

	function automatic logic [7:0] csp_div_mask(input logic [3:0] sel);
		csp_div_mask = 8'(({9'h000, 1'b1} << sel) - 10'h001);
	endfunction : csp_div_mask

endpackage : csp_pkg

// File: core/csp_prescaler.sv
// Power-of-two divider on the selected source ticks, switching only on a period boundary.
`timescale 1ns/1ps
`default_nettype none
module csp_prescaler
	import csp_pkg::*;
(
	// Clock and reset.
	input  wire logic       core_clk,
	input  wire logic       sys_rst,
	// Source and setting.
	input  wire logic       srcTick,
	input  wire logic [3:0] selIn,
	// Divided output.
	output logic            divTick,
	output logic [3:0]      activeSel
);
	logic [7:0] cntReg;
	logic [7:0] cntNext;
	logic [3:0] selReg;
	logic [3:0] selNext;
	logic       boundary;

	// One stage per source tick, like a ripple counter on the undivided clock.
	assign boundary = srcTick && ((cntReg & csp_div_mask(selReg)) == csp_div_mask(selReg));

	always_comb begin
		cntNext = cntReg;
		selNext = selReg;
		if (boundary) begin
			// A new setting waits for the old period to end, so no short period appears.
			if (selIn != selReg) begin
				selNext = selIn;
				cntNext = 8'h00;
			end else begin
				cntNext = cntReg + 8'h01;
			end
		end else if (srcTick) begin
			cntNext = cntReg + 8'h01;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cntReg <= 8'h00;
			selReg <= selIn;
		end else begin
			cntReg <= cntNext;
			selReg <= selNext;
		end
	end

	assign divTick   = boundary;
	assign activeSel = selReg;
endmodule : csp_prescaler
`default_nettype wire

// File: core/csp_startup_timer.sv
// Start-up delay: source cycles first, then watchdog oscillator cycles.
`timescale 1ns/1ps
`default_nettype none
module csp_startup_timer
	import csp_pkg::*;
(
	// Clock and reset.
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	// Control.
	input  wire logic        startPulse,
	input  wire logic        abortHold,
	input  wire logic [15:0] srcCount,
	input  wire logic [13:0] wdtCount,
	// Time bases.
	input  wire logic        srcTick,
	input  wire logic        wdtTick,
	// Result.
	output logic             startDone
);
	csp_start_state_t stateReg;
	csp_start_state_t stateNext;
	logic [15:0]      srcCntReg;
	logic [15:0]      srcCntNext;
	logic [13:0]      wdtCntReg;
	logic [13:0]      wdtCntNext;
	logic [13:0]      wdtTargetReg;
	logic [13:0]      wdtTargetNext;

	always_comb begin
		stateNext     = stateReg;
		srcCntNext    = srcCntReg;
		wdtCntNext    = wdtCntReg;
		wdtTargetNext = wdtTargetReg;
		if (abortHold) begin
			stateNext = ST_IDLE;
		end else if (startPulse) begin
			stateNext     = ST_SRC_WAIT;
			srcCntNext    = srcCount;
			wdtCntNext    = 14'h0000;
			wdtTargetNext = wdtCount;
		end else begin
			case (stateReg)
				ST_SRC_WAIT: begin
					if (srcCntReg == 16'h0000) begin
						stateNext = (wdtTargetReg == 14'h0000) ? ST_DONE : ST_WDT_WAIT;
					end else if (srcTick) begin
						srcCntNext = srcCntReg - 16'h0001;
					end
				end
				ST_WDT_WAIT: begin
					// The real-time part counts the watchdog oscillator whatever drives the core.
					if (wdtCntReg == wdtTargetReg) begin
						stateNext = ST_DONE;
					end else if (wdtTick) begin
						wdtCntNext = wdtCntReg + 14'h0001;
					end
				end
				ST_IDLE: stateNext = ST_IDLE;
				ST_DONE: stateNext = ST_DONE;
				default: stateNext = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			stateReg     <= ST_IDLE;
			srcCntReg    <= 16'h0000;
			wdtCntReg    <= 14'h0000;
			wdtTargetReg <= 14'h0000;
		end else begin
			stateReg     <= stateNext;
			srcCntReg    <= srcCntNext;
			wdtCntReg    <= wdtCntNext;
			wdtTargetReg <= wdtTargetNext;
		end
	end

	assign startDone = (stateReg == ST_DONE);
endmodule : csp_startup_timer
`default_nettype wire

// File: test/csp_clock_control_chk.sv
// Concurrent checks on the clock control ports.
`timescale 1ns/1ps
`default_nettype none
module csp_clock_control_chk #(
	parameter int LF_LONG_CYCLES  = 64,
	parameter int WDT_LONG_CYCLES = 32
) (
	// Clock, reset and bus.
	input wire logic        core_clk, sys_rst, psel, penable, pwrite, pslverr,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	// Trim, power-down and domain enables.
	input wire logic [7:0]  factoryTrim, rcTrimValue,
	input wire logic        sleepReq, watchdogTick, clocksRunning,
	input wire logic        coreDomainClockEn, peripheralDomainClockEn,
	input wire logic        converterDomainClockEn, programMemoryDomainClockEn
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	chk_gated_start: assert property (!clocksRunning |-> !coreDomainClockEn)
		else $error("domain enable before start-up ended");
	chk_domains_equal: assert property (coreDomainClockEn == peripheralDomainClockEn
		&& coreDomainClockEn == converterDomainClockEn
		&& coreDomainClockEn == programMemoryDomainClockEn) else $error("domain enables differ");
	chk_no_short: assert property ($rose(coreDomainClockEn) |=> !coreDomainClockEn[*3])
		else $error("divided period too short");
	chk_wdt_pulse: assert property (watchdogTick |=> !watchdogTick[*3])
		else $error("watchdog tick too close");
	chk_sleep_gate: assert property (sleepReq[*3] |-> !coreDomainClockEn)
		else $error("enable during power-down");
	chk_wake_delay: assert property ($fell(sleepReq) |-> !coreDomainClockEn[*8])
		else $error("wake-up too early");
	chk_reset_quiet: assert property (disable iff (1'b0) sys_rst |=>
		!clocksRunning && !watchdogTick && !coreDomainClockEn) else $error("activity in reset");
	chk_trim_load: assert property (disable iff (1'b0) sys_rst[*3] |=>
		rcTrimValue == factoryTrim) else $error("trim not loaded in reset");
	chk_trim_write: assert property (psel && penable && pwrite && paddr == 12'h004 |=>
		rcTrimValue == 8'($past(pwdata))) else $error("trim write lost");
	chk_unmapped_err: assert property (psel && penable && paddr > 12'h008 |-> pslverr)
		else $error("no error on unmapped address");
endmodule : csp_clock_control_chk
bind csp_clock_control csp_clock_control_chk #(.LF_LONG_CYCLES(LF_LONG_CYCLES),
	.WDT_LONG_CYCLES(WDT_LONG_CYCLES)) i_csp_clock_control_chk (.core_clk(core_clk),
	.sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .pslverr(pslverr),
	.paddr(paddr), .pwdata(pwdata), .factoryTrim(factoryTrim), .rcTrimValue(rcTrimValue),
	.sleepReq(sleepReq), .watchdogTick(watchdogTick), .clocksRunning(clocksRunning),
	.coreDomainClockEn(coreDomainClockEn), .peripheralDomainClockEn(peripheralDomainClockEn),
	.converterDomainClockEn(converterDomainClockEn),
	.programMemoryDomainClockEn(programMemoryDomainClockEn));
`default_nettype wire

// File: test/csp_clock_control_tb.sv
// Self-checking bench for source selection, start-up gating and prescaling.
`timescale 1ns/1ps
`default_nettype none
module csp_clock_control_tb;
	localparam int LFL = 64;
	localparam int WDL = 32;
	logic        core_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rv;
	logic        pready, pslverr, re, watchdogTick, clocksRunning, sleepReq = 1'b0, div8 = 1'b1;
	logic [3:0]  src = 4'h2;
	logic [1:0]  startup_time_fuses = 2'h0;
	logic [7:0]  trim = 8'h5A, rcTrimValue;
	logic        extClk, rcOsc, lpOsc, lfOsc, coreEn, perEn, cnvEn, pmEn;
	logic [3:0]  srcs [5] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h1};
	int          fail_count = 0, tests_run = 0, cyc = 0;
	csp_osc_model i_csp_osc_model (.core_clk(core_clk), .externalClockInput(extClk),
		.rcOscillator(rcOsc), .lowPowerOscillator(lpOsc), .lowFreqCrystal(lfOsc));
	csp_clock_control #(.LF_LONG_CYCLES(LFL), .WDT_LONG_CYCLES(WDL)) i_csp_clock_control (
		.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .clockSourceSelectFuses(src), .startupTimeFuses(startup_time_fuses),
		.divideByEightFuse(div8), .factoryTrim(trim), .externalClockInput(extClk),
		.rcOscillator(rcOsc), .lowPowerOscillator(lpOsc), .lowFreqCrystal(lfOsc),
		.sleepReq(sleepReq), .rcTrimValue(rcTrimValue), .watchdogTick(watchdogTick),
		.coreDomainClockEn(coreEn), .peripheralDomainClockEn(perEn),
		.converterDomainClockEn(cnvEn), .programMemoryDomainClockEn(pmEn),
		.clocksRunning(clocksRunning));
	always #5 core_clk = ~core_clk;
	// Source periods in core cycles; reserved codes run from the internal RC.
	function automatic int per(input logic [3:0] s);
		case (s)
			4'h0: return 6;
			4'h4: return 10;
			4'h6: return 8;
			default: return 4;
		endcase
	endfunction : per
	function automatic int bootTime(input logic [3:0] s, input logic [1:0] u);
		int t;
		int w;
		t = (s == 4'h6) ? ((u < 2) ? 1024 : LFL) : 14;
		w = (s == 4'h6) ? ((u == 0) ? 512 : WDL) : ((u == 0) ? 0 : (u == 1) ? 512 : WDL);
		return t * per(s) + w * 10;
	endfunction : bootTime
	task end_of_test;
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : end_of_test
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 90000) begin
			fail_count++;
			$display("[ERR] %0t run timed out", $time);
			end_of_test();
		end
	end
	task check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// The caller enters just after an edge; psel stays up so writes can run back to back.
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin @(posedge core_clk); end while (pready !== 1'b1);
		rv = prdata;
		re = pslverr;
		penable <= 1'b0;
	endtask : apb
	task idle;
		psel <= 1'b0;
		@(posedge core_clk);
	endtask : idle
	task gap(input bit wd, output int k, output int n);
		k = 0;
		n = 0;
		do begin @(posedge core_clk); k++; end while ((wd ? watchdogTick : coreEn) !== 1'b1 && k < 3000);
		do begin @(posedge core_clk); n++; end while ((wd ? watchdogTick : coreEn) !== 1'b1 && n < 3000);
	endtask : gap
	task boot(input logic [3:0] s, input logic [1:0] u, input logic f, output int n);
		sys_rst <= 1'b1;
		src <= s;
		startup_time_fuses <= u;
		div8 <= f;
		trim <= 8'($urandom);
		repeat (5) @(posedge core_clk);
		sys_rst <= 1'b0;
		n = 0;
		do begin @(posedge core_clk); n++; end while (clocksRunning !== 1'b1 && n < 20000);
	endtask : boot
	initial begin
		int n, e, t, k, k2, n2, prev;
		logic [3:0] s;
		logic [1:0] u;
		logic f;
		logic [31:0] d;
		void'($urandom(32'h6AE371DC));
		for (int i = 0; i < 17; i++) begin
			s = srcs[i / 4];
			u = (i == 16) ? 2'($urandom) : 2'(i % 4);
			f = 1'($urandom);
			boot(s, u, f, n);
			e = bootTime(s, u);
			t = 2 * per(s) + 40;
			check(32'(n >= e - t && n <= e + t), 32'h1);
			apb(1'b0, 12'h000, 32'h0);
			check(rv & 32'hF, f ? 32'h0 : 32'h3);
			apb(1'b0, 12'h004, 32'h0);
			check(rv, {24'h0, trim});
			apb(1'b0, 12'h008, 32'h0);
			idle();
			check(rv & 32'hFFFFFFF7, {20'h0, s, f ? 4'h0 : 4'h3, 1'b0, u == 2'h3,
				!(s inside {4'h0, 4'h2, 4'h4, 4'h6}), 1'b1});
			gap(1'b0, k, n);
			check(32'(n), 32'(per(s) << (f ? 0 : 3)));
			$display("boot test %0d done", i);
		end
		boot(4'h2, 2'h0, 1'b1, n);
		gap(1'b1, k, n);
		check(32'(n), 32'd10);
		apb(1'b0, 12'h00C, 32'h0);
		check({rv[30:0], re}, 32'h1);
		d = $urandom;
		apb(1'b1, 12'h004, d);
		apb(1'b0, 12'h004, 32'h0);
		idle();
		check(rv, {24'h0, d[7:0]});
		$display("bus test done");
		sleepReq <= 1'b1;
		repeat (3) @(posedge core_clk);
		n = 0;
		repeat (17) begin @(posedge core_clk); n += int'(coreEn === 1'b1); end
		check(32'(n), 32'h0);
		sleepReq <= 1'b0;
		n = 0;
		do begin @(posedge core_clk); n++; end while (coreEn !== 1'b1 && n < 100);
		check(32'(n >= 18 && n <= 40), 32'h1);
		$display("sleep test done");
		apb(1'b1, 12'h000, 32'h2);
		apb(1'b1, 12'h000, 32'h80);
		apb(1'b1, 12'h000, 32'h9);
		apb(1'b1, 12'h000, 32'h80);
		apb(1'b0, 12'h000, 32'h0);
		check(32'(rv[7]), 32'h1);
		// One idle cycle lets the window run out, so the select write must be refused.
		idle();
		apb(1'b1, 12'h000, 32'h1);
		apb(1'b0, 12'h000, 32'h0);
		idle();
		check(rv & 32'hFF, 32'h0);
		$display("refusal test done");
		prev = 4;
		for (int j = 0; j < 9; j++) begin
			apb(1'b1, 12'h000, 32'h80);
			apb(1'b1, 12'h000, 32'(j));
			idle();
			gap(1'b0, k, n);
			gap(1'b0, k2, n2);
			check(32'(k2), 32'(4 << j));
			check(32'(n2), 32'(4 << j));
			check(32'(k + n + k2 <= prev + 2 * (4 << j) + 8), 32'h1);
			apb(1'b0, 12'h008, 32'h0);
			idle();
			check((rv >> 4) & 32'hF, 32'(j));
			prev = 4 << j;
		end
		$display("prescale test done");
		end_of_test();
	end
endmodule : csp_clock_control_tb
`default_nettype wire

// File: test/csp_osc_model.sv
// Free-running oscillator sources seen by the clock control block.
`timescale 1ns/1ps
`default_nettype none
module csp_osc_model (
	// Core clock that paces the model.
	input  wire logic core_clk,
	// Oscillator levels.
	output logic      externalClockInput,
	output logic      rcOscillator,
	output logic      lowPowerOscillator,
	output logic      lowFreqCrystal
);
	// Each half period is fixed, so no source drifts from one cycle to the next.
	localparam int HALF [4] = '{3, 2, 5, 4};
	int         cnt [4] = '{0, 0, 0, 0};
	logic [3:0] lvl = 4'h0;
	always @(posedge core_clk) begin
		for (int i = 0; i < 4; i++) begin
			if (cnt[i] == HALF[i] - 1) begin
				cnt[i] <= 0;
				lvl[i] <= ~lvl[i];
			end else begin
				cnt[i] <= cnt[i] + 1;
			end
		end
	end
	assign {lowFreqCrystal, lowPowerOscillator, rcOscillator, externalClockInput} = lvl;
endmodule : csp_osc_model
`default_nettype wire
